// >>> pkg/opcode_decoder_regs.vh
// Opcode ranges, field positions and class codes for the short opcode decoder
`ifndef OPCODE_DECODER_REGS_VH
`define OPCODE_DECODER_REGS_VH

// Class codes driven on the operation class output
`define CLS_NONE 5'h00
`define CLS_INT_DIS 5'h01
`define CLS_INT_EN 5'h02
`define CLS_RAISE 5'h03
`define CLS_LOCK 5'h04
`define CLS_INVAL 5'h05
`define CLS_POPMULT 5'h06
`define CLS_PLT_U 5'h07
`define CLS_DLE_U 5'h08
`define CLS_PLE_U 5'h09
`define CLS_DEQ_I 5'h0A
`define CLS_PEQ_I 5'h0B
`define CLS_DLT_I 5'h0C
`define CLS_PLT_I 5'h0D
`define CLS_DLE_I 5'h0E
`define CLS_PLE_I 5'h0F
`define CLS_DLT_UI 5'h10
`define CLS_PLT_UI 5'h11
`define CLS_DLE_UI 5'h12
`define CLS_PLE_UI 5'h13
`define CLS_COUNT 20

// Range bounds, inclusive
`define R_INT_DIS_LO 16'h0030
`define R_INT_DIS_HI 16'h0037
`define R_INT_EN_LO 16'h0040
`define R_INT_EN_HI 16'h0047
`define R_RAISE_LO 16'h0090
`define R_RAISE_HI 16'h009F
`define R_LOCK_LO 16'h00B0
`define R_LOCK_HI 16'h00B5
`define R_INVAL_LO 16'h0268
`define R_INVAL_HI 16'h026F
`define R_POPMULT_LO 16'h0580
`define R_POPMULT_HI 16'h05BD
`define R_PLT_U_LO 16'h09C0
`define R_PLT_U_HI 16'h09FF
`define R_DLE_U_LO 16'h0A00
`define R_DLE_U_HI 16'h0A3F
`define R_PLE_U_LO 16'h0A40
`define R_PLE_U_HI 16'h0A7F
`define R_DEQ_I_LO 16'h0C00
`define R_DEQ_I_HI 16'h0C3F
`define R_PEQ_I_LO 16'h0C40
`define R_PEQ_I_HI 16'h0C7F
`define R_DLT_I_LO 16'h0C80
`define R_DLT_I_HI 16'h0CBF
`define R_PLT_I_LO 16'h0CC0
`define R_PLT_I_HI 16'h0CFF
`define R_DLE_I_LO 16'h0D00
`define R_DLE_I_HI 16'h0D3F
`define R_PLE_I_LO 16'h0D40
`define R_PLE_I_HI 16'h0D7F
`define R_DLT_UI_LO 16'h0D80
`define R_DLT_UI_HI 16'h0DBF
`define R_PLT_UI_LO 16'h0DC0
`define R_PLT_UI_HI 16'h0DFF
`define R_DLE_UI_LO 16'h0E00
`define R_DLE_UI_HI 16'h0E3F
`define R_PLE_UI_LO 16'h0E40
`define R_PLE_UI_HI 16'h0E7F

// Operand fields
`define F_REGA_HI 2
`define F_REGA_LO 0
`define F_REGB_HI 5
`define F_REGB_LO 3
`define F_IMM4_HI 3
`define F_IMM4_LO 0
`define F_POPD_HI 5
`define F_POPD_LO 3
`define F_POPP_HI 2
`define F_POPP_LO 0
`define F_SIGN3 5

`endif

// >>> core/range_match.v
// Inclusive range comparator for one opcode window
`timescale 1ns/100ps
`default_nettype none

module range_match (
    input wire [15:0] word_i,
    input wire [15:0] lo_i,
    input wire [15:0] hi_i,
    output wire hit_o
);

    // Word lies between both bounds
    assign hit_o = (word_i >= lo_i) && (word_i <= hi_i);

endmodule // range_match

`default_nettype wire

// >>> core/short_opcode_control_compare_decoder.v
// Decoder for low 16-bit control, stack and compare opcodes
//
// Overview of operation
// - Every covered opcode is one 16-bit word.
// - 0x0030-0x0037 interrupt disable, one data register.
// - 0x0040-0x0047 interrupt enable, one data register.
// - 0x0090-0x009F forced event, 4-bit immediate.
// - 0x00B0-0x00B5 atomic byte lock via pointer.
// - 0x0268-0x026F cache line invalidate, pointer post-increment.
// - 0x0580-0x05BD combined multi-register pop, two limits.
// - 0x09C0-0x09FF unsigned pointer less-than compare.
// - 0x0A00-0x0A3F unsigned data less-or-equal compare.
// - 0x0A40-0x0A7F unsigned pointer less-or-equal compare.
// - 0x0C00-0x0C3F data equals signed immediate.
// - 0x0C40-0x0C7F pointer equals signed immediate.
// - 0x0C80-0x0CBF data signed less-than immediate.
// - 0x0CC0-0x0CFF pointer signed less-than immediate.
// - 0x0D00-0x0D3F data signed less-or-equal immediate.
// - 0x0D40-0x0D7F pointer signed less-or-equal immediate.
// - 0x0D80-0x0DBF data unsigned less-than immediate.
// - 0x0E00-0x0E3F data unsigned less-or-equal immediate.
// - 0x0E40-0x0E7F pointer unsigned less-or-equal immediate.
`timescale 1ns/100ps
`default_nettype none
`include "opcode_decoder_regs.vh"

module short_opcode_control_compare_decoder (
    input wire CLK_I,
    input wire RST_I,
    input wire [15:0] OPCODE_I,
    input wire OPCODE_VALID_I,
    output reg DEC_VALID_O,
    output reg [4:0] OP_CLASS_O,
    output reg ILLEGAL_O,
    output reg INTERRUPT_DISABLE_OP_O,
    output reg INTERRUPT_ENABLE_OP_O,
    output reg RAISE_OP_O,
    output reg ATOMIC_BYTE_LOCK_OP_O,
    output reg DCACHE_LINE_INVALIDATE_OP_O,
    output reg POP_MULTIPLE_OP_O,
    output reg COMPARE_OP_O,
    output reg CONDITION_FLAG_WE_O,
    output reg UNSIGNED_COMPARE_OPTION_O,
    output reg [1:0] COMPARE_KIND_O,
    output reg COMPARE_USES_IMM_O,
    output reg OPERAND_IS_POINTER_O,
    output reg [2:0] REG_A_O,
    output reg [2:0] REG_B_O,
    output reg [31:0] IMMEDIATE_O,
    output reg POST_INCREMENT_O,
    output reg [2:0] DATA_REG_LIMIT_O,
    output reg [2:0] POINTER_REG_LIMIT_O,
    output reg STACK_POINTER_REG_UPDATE_O
);

    // Compare kinds
    localparam [1:0] KIND_EQ = 2'h0;
    localparam [1:0] KIND_LT = 2'h1;
    localparam [1:0] KIND_LE = 2'h2;

    // Range bound tables, one entry per class after none
    wire [16*`CLS_COUNT-1:0] lo_tab;
    wire [16*`CLS_COUNT-1:0] hi_tab;
    // One hit per class
    wire [`CLS_COUNT-1:0] hit;

    assign lo_tab = {16'h0000,
        `R_PLE_UI_LO, `R_DLE_UI_LO, `R_PLT_UI_LO, `R_DLT_UI_LO,
        `R_PLE_I_LO, `R_DLE_I_LO, `R_PLT_I_LO, `R_DLT_I_LO,
        `R_PEQ_I_LO, `R_DEQ_I_LO, `R_PLE_U_LO, `R_DLE_U_LO,
        `R_PLT_U_LO, `R_POPMULT_LO, `R_INVAL_LO, `R_LOCK_LO,
        `R_RAISE_LO, `R_INT_EN_LO, `R_INT_DIS_LO};
    assign hi_tab = {16'h0000,
        `R_PLE_UI_HI, `R_DLE_UI_HI, `R_PLT_UI_HI, `R_DLT_UI_HI,
        `R_PLE_I_HI, `R_DLE_I_HI, `R_PLT_I_HI, `R_DLT_I_HI,
        `R_PEQ_I_HI, `R_DEQ_I_HI, `R_PLE_U_HI, `R_DLE_U_HI,
        `R_PLT_U_HI, `R_POPMULT_HI, `R_INVAL_HI, `R_LOCK_HI,
        `R_RAISE_HI, `R_INT_EN_HI, `R_INT_DIS_HI};

    // One comparator per class window; entry 0 unused and tied off
    genvar gi;
    generate
        for (gi = 0; gi < `CLS_COUNT; gi = gi + 1) begin : g_rng
            if (gi == 0) begin : g_none
                assign hit[gi] = 1'b0;
            end else begin : g_cmp
                range_match u_rm (
                    .word_i(OPCODE_I),
                    .lo_i(lo_tab[16*(gi-1) +: 16]),
                    .hi_i(hi_tab[16*(gi-1) +: 16]),
                    .hit_o(hit[gi])
                );
            end
        end
    endgenerate

    // Next values of the class, compare and immediate outputs
    reg [4:0] cls_d;
    reg cmp_d;
    reg uns_d;
    reg [1:0] kind_d;
    reg imm_d;
    reg ptr_d;
    reg [31:0] immv_d;
    integer k;

    // Class priority encoder; windows are disjoint
    always @* begin
        cls_d = `CLS_NONE;
        for (k = 1; k < `CLS_COUNT; k = k + 1) begin
            if (hit[k]) begin
                cls_d = k[4:0];
            end
        end
    end

    // Compare attributes by class
    always @* begin
        cmp_d = 1'b1;
        uns_d = 1'b0;
        kind_d = KIND_EQ;
        imm_d = 1'b0;
        ptr_d = 1'b0;
        immv_d = 32'h00000000;
        case (cls_d)
            `CLS_PLT_U: begin
                uns_d = 1'b1;
                kind_d = KIND_LT;
                ptr_d = 1'b1;
            end
            `CLS_DLE_U: begin
                uns_d = 1'b1;
                kind_d = KIND_LE;
            end
            `CLS_PLE_U: begin
                uns_d = 1'b1;
                kind_d = KIND_LE;
                ptr_d = 1'b1;
            end
            `CLS_DEQ_I: begin
                imm_d = 1'b1;
            end
            `CLS_PEQ_I: begin
                imm_d = 1'b1;
                ptr_d = 1'b1;
            end
            `CLS_DLT_I: begin
                imm_d = 1'b1;
                kind_d = KIND_LT;
            end
            `CLS_PLT_I: begin
                imm_d = 1'b1;
                kind_d = KIND_LT;
                ptr_d = 1'b1;
            end
            `CLS_DLE_I: begin
                imm_d = 1'b1;
                kind_d = KIND_LE;
            end
            `CLS_PLE_I: begin
                imm_d = 1'b1;
                kind_d = KIND_LE;
                ptr_d = 1'b1;
            end
            `CLS_DLT_UI: begin
                imm_d = 1'b1;
                uns_d = 1'b1;
                kind_d = KIND_LT;
            end
            `CLS_PLT_UI: begin
                imm_d = 1'b1;
                uns_d = 1'b1;
                kind_d = KIND_LT;
                ptr_d = 1'b1;
            end
            `CLS_DLE_UI: begin
                imm_d = 1'b1;
                uns_d = 1'b1;
                kind_d = KIND_LE;
            end
            `CLS_PLE_UI: begin
                imm_d = 1'b1;
                uns_d = 1'b1;
                kind_d = KIND_LE;
                ptr_d = 1'b1;
            end
            // Not a compare
            default: begin
                cmp_d = 1'b0;
            end
        endcase
        // Compare immediate from the field in bits 5..3, raise immediate from bits 3..0
        if (imm_d && uns_d) begin
            immv_d = {29'h0, OPCODE_I[`F_REGB_HI:`F_REGB_LO]};
        end else if (imm_d) begin
            immv_d = {{29{OPCODE_I[`F_SIGN3]}}, OPCODE_I[`F_REGB_HI:`F_REGB_LO]};
        end else if (cls_d == `CLS_RAISE) begin
            immv_d = {28'h0000000, OPCODE_I[`F_IMM4_HI:`F_IMM4_LO]};
        end
    end

    // Registered outputs, one word decoded per valid cycle
    always @(posedge CLK_I) begin
        if (RST_I) begin
            DEC_VALID_O <= 1'b0;
            OP_CLASS_O <= `CLS_NONE;
            ILLEGAL_O <= 1'b0;
            INTERRUPT_DISABLE_OP_O <= 1'b0;
            INTERRUPT_ENABLE_OP_O <= 1'b0;
            RAISE_OP_O <= 1'b0;
            ATOMIC_BYTE_LOCK_OP_O <= 1'b0;
            DCACHE_LINE_INVALIDATE_OP_O <= 1'b0;
            POP_MULTIPLE_OP_O <= 1'b0;
            COMPARE_OP_O <= 1'b0;
            CONDITION_FLAG_WE_O <= 1'b0;
            UNSIGNED_COMPARE_OPTION_O <= 1'b0;
            COMPARE_KIND_O <= KIND_EQ;
            COMPARE_USES_IMM_O <= 1'b0;
            OPERAND_IS_POINTER_O <= 1'b0;
            REG_A_O <= 3'h0;
            REG_B_O <= 3'h0;
            IMMEDIATE_O <= 32'h00000000;
            POST_INCREMENT_O <= 1'b0;
            DATA_REG_LIMIT_O <= 3'h0;
            POINTER_REG_LIMIT_O <= 3'h0;
            STACK_POINTER_REG_UPDATE_O <= 1'b0;
        end else begin
            DEC_VALID_O <= OPCODE_VALID_I;
            OP_CLASS_O <= OPCODE_VALID_I ? cls_d : `CLS_NONE;
            ILLEGAL_O <= OPCODE_VALID_I && (cls_d == `CLS_NONE);
            INTERRUPT_DISABLE_OP_O <= OPCODE_VALID_I && hit[`CLS_INT_DIS];
            INTERRUPT_ENABLE_OP_O <= OPCODE_VALID_I && hit[`CLS_INT_EN];
            RAISE_OP_O <= OPCODE_VALID_I && hit[`CLS_RAISE];
            ATOMIC_BYTE_LOCK_OP_O <= OPCODE_VALID_I && hit[`CLS_LOCK];
            DCACHE_LINE_INVALIDATE_OP_O <= OPCODE_VALID_I && hit[`CLS_INVAL];
            POP_MULTIPLE_OP_O <= OPCODE_VALID_I && hit[`CLS_POPMULT];
            COMPARE_OP_O <= OPCODE_VALID_I && cmp_d;
            CONDITION_FLAG_WE_O <= OPCODE_VALID_I && cmp_d;
            UNSIGNED_COMPARE_OPTION_O <= OPCODE_VALID_I && uns_d;
            COMPARE_KIND_O <= OPCODE_VALID_I ? kind_d : KIND_EQ;
            COMPARE_USES_IMM_O <= OPCODE_VALID_I && imm_d;
            // Pointer operand for lock, invalidate and pointer compares
            OPERAND_IS_POINTER_O <= OPCODE_VALID_I &&
                (ptr_d || hit[`CLS_LOCK] || hit[`CLS_INVAL]);
            REG_A_O <= OPCODE_VALID_I ? OPCODE_I[`F_REGA_HI:`F_REGA_LO] : 3'h0;
            REG_B_O <= (OPCODE_VALID_I && cmp_d && !imm_d) ?
                OPCODE_I[`F_REGB_HI:`F_REGB_LO] : 3'h0;
            IMMEDIATE_O <= OPCODE_VALID_I ? immv_d : 32'h00000000;
            POST_INCREMENT_O <= OPCODE_VALID_I &&
                (hit[`CLS_INVAL] || hit[`CLS_POPMULT]);
            DATA_REG_LIMIT_O <= (OPCODE_VALID_I && hit[`CLS_POPMULT]) ?
                OPCODE_I[`F_POPD_HI:`F_POPD_LO] : 3'h0;
            POINTER_REG_LIMIT_O <= (OPCODE_VALID_I && hit[`CLS_POPMULT]) ?
                OPCODE_I[`F_POPP_HI:`F_POPP_LO] : 3'h0;
            STACK_POINTER_REG_UPDATE_O <= OPCODE_VALID_I && hit[`CLS_POPMULT];
        end
    end

endmodule // short_opcode_control_compare_decoder

`default_nettype wire

// >>> test/fetch_model.sv
// Instruction fetch path model that hands opcode words to the decoder
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [15:0] word_i,
    output var logic [15:0] opcode_o = 16'h0000,
    output var logic valid_o = 1'b0
);
    always @(negedge clk_i) begin
        if (req_i) begin
            // One complete 16-bit word per valid cycle
            opcode_o <= word_i;
            valid_o <= 1'b1;
        end else begin
            // Idle bus keeps moving so a stale word never looks held
            opcode_o <= ~opcode_o;
            valid_o <= 1'b0;
        end
    end
endmodule // fetch_model
`default_nettype wire

// >>> test/opdec_checker.sv
// Concurrent checks on the short opcode decoder ports
`timescale 1ns/100ps
`default_nettype none
`include "opcode_decoder_regs.vh"
module opdec_checker (
    input wire CLK_I,
    input wire RST_I,
    input wire [15:0] OPCODE_I,
    input wire OPCODE_VALID_I,
    input wire DEC_VALID_O,
    input wire [4:0] OP_CLASS_O,
    input wire ILLEGAL_O,
    input wire INTERRUPT_DISABLE_OP_O,
    input wire RAISE_OP_O,
    input wire DCACHE_LINE_INVALIDATE_OP_O,
    input wire POP_MULTIPLE_OP_O,
    input wire COMPARE_OP_O,
    input wire CONDITION_FLAG_WE_O,
    input wire UNSIGNED_COMPARE_OPTION_O,
    input wire [1:0] COMPARE_KIND_O,
    input wire COMPARE_USES_IMM_O,
    input wire OPERAND_IS_POINTER_O,
    input wire [31:0] IMMEDIATE_O,
    input wire POST_INCREMENT_O,
    input wire [2:0] DATA_REG_LIMIT_O,
    input wire STACK_POINTER_REG_UPDATE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic [15:0] op_q; // Word taken at the previous edge
    logic v_q; // That word was valid outside reset
    // Keeps the cause that the present outputs answer
    always @(posedge CLK_I) begin
        op_q <= OPCODE_I;
        v_q <= OPCODE_VALID_I & ~RST_I;
    end
    property p_valid; DEC_VALID_O == v_q; endproperty
    a_valid: assert property (p_valid) else $error("decode valid off");
    property p_dis; v_q && op_q inside {[16'h0030:16'h0037]} |->
        INTERRUPT_DISABLE_OP_O && OP_CLASS_O == `CLS_INT_DIS; endproperty
    a_dis: assert property (p_dis) else $error("disable decode wrong");
    property p_raise; v_q && op_q[15:4] == 12'h009 |->
        RAISE_OP_O && IMMEDIATE_O == {28'h0, op_q[3:0]}; endproperty
    a_raise: assert property (p_raise) else $error("raise decode wrong");
    property p_inval; v_q && op_q inside {[16'h0268:16'h026F]} |->
        DCACHE_LINE_INVALIDATE_OP_O && POST_INCREMENT_O && OPERAND_IS_POINTER_O; endproperty
    a_inval: assert property (p_inval) else $error("invalidate decode wrong");
    property p_pop; v_q && op_q inside {[16'h0580:16'h05BD]} |-> POP_MULTIPLE_OP_O &&
        STACK_POINTER_REG_UPDATE_O && DATA_REG_LIMIT_O == op_q[5:3]; endproperty
    a_pop: assert property (p_pop) else $error("pop decode wrong");
    property p_cmp; v_q && op_q inside {[16'h09C0:16'h09FF]} |-> COMPARE_OP_O &&
        CONDITION_FLAG_WE_O && UNSIGNED_COMPARE_OPTION_O && COMPARE_KIND_O == 2'h1; endproperty
    a_cmp: assert property (p_cmp) else $error("pointer compare wrong");
    property p_simm; v_q && op_q inside {[16'h0C00:16'h0D7F]} |-> COMPARE_USES_IMM_O &&
        !UNSIGNED_COMPARE_OPTION_O && IMMEDIATE_O == {{29{op_q[5]}}, op_q[5:3]}; endproperty
    a_simm: assert property (p_simm) else $error("signed immediate wrong");
    property p_pltui; v_q && op_q inside {[16'h0DC0:16'h0DFF]} |->
        OP_CLASS_O == `CLS_PLT_UI && OPERAND_IS_POINTER_O; endproperty
    a_pltui: assert property (p_pltui) else $error("pointer uimm compare wrong");
    property p_ill; v_q && op_q inside {[16'h0A80:16'h0BFF]} |->
        ILLEGAL_O && OP_CLASS_O == `CLS_NONE && !COMPARE_OP_O; endproperty
    a_ill: assert property (p_ill) else $error("gap word not illegal");
endmodule // opdec_checker
bind short_opcode_control_compare_decoder opdec_checker u_opdec_checker (
    .CLK_I(CLK_I), .RST_I(RST_I), .OPCODE_I(OPCODE_I), .OPCODE_VALID_I(OPCODE_VALID_I),
    .DEC_VALID_O(DEC_VALID_O), .OP_CLASS_O(OP_CLASS_O), .ILLEGAL_O(ILLEGAL_O),
    .INTERRUPT_DISABLE_OP_O(INTERRUPT_DISABLE_OP_O), .RAISE_OP_O(RAISE_OP_O),
    .DCACHE_LINE_INVALIDATE_OP_O(DCACHE_LINE_INVALIDATE_OP_O),
    .POP_MULTIPLE_OP_O(POP_MULTIPLE_OP_O), .COMPARE_OP_O(COMPARE_OP_O),
    .CONDITION_FLAG_WE_O(CONDITION_FLAG_WE_O), .COMPARE_KIND_O(COMPARE_KIND_O),
    .UNSIGNED_COMPARE_OPTION_O(UNSIGNED_COMPARE_OPTION_O),
    .COMPARE_USES_IMM_O(COMPARE_USES_IMM_O), .OPERAND_IS_POINTER_O(OPERAND_IS_POINTER_O),
    .IMMEDIATE_O(IMMEDIATE_O), .POST_INCREMENT_O(POST_INCREMENT_O),
    .DATA_REG_LIMIT_O(DATA_REG_LIMIT_O),
    .STACK_POINTER_REG_UPDATE_O(STACK_POINTER_REG_UPDATE_O));
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the short opcode decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic CLK_I = 1'b0; // Core clock
    logic RST_I = 1'b1; // Sync reset
    logic req = 1'b0; // Word request to the fetch model
    logic [15:0] wd = 16'h0000; // Word handed to the fetch model
    logic [15:0] OPCODE_I;
    logic OPCODE_VALID_I, DEC_VALID_O, ILLEGAL_O, INTERRUPT_DISABLE_OP_O, INTERRUPT_ENABLE_OP_O;
    logic RAISE_OP_O, ATOMIC_BYTE_LOCK_OP_O, DCACHE_LINE_INVALIDATE_OP_O, POP_MULTIPLE_OP_O;
    logic COMPARE_OP_O, CONDITION_FLAG_WE_O, UNSIGNED_COMPARE_OPTION_O, COMPARE_USES_IMM_O;
    logic OPERAND_IS_POINTER_O, POST_INCREMENT_O, STACK_POINTER_REG_UPDATE_O;
    logic [4:0] OP_CLASS_O;
    logic [1:0] COMPARE_KIND_O;
    logic [2:0] REG_A_O, REG_B_O, DATA_REG_LIMIT_O, POINTER_REG_LIMIT_O;
    logic [31:0] IMMEDIATE_O;
    int failures = 0; // Mismatch count
    int n_tests = 0; // Comparison count
    logic [15:0] wl[$]; // Words of one stream
    logic [4:0] cl[$]; // Expected class per word, zero for illegal
    // Range bounds in class order, class code is index plus one
    logic [15:0] lo[19] = '{16'h0030, 16'h0040, 16'h0090, 16'h00B0, 16'h0268, 16'h0580,
        16'h09C0, 16'h0A00, 16'h0A40, 16'h0C00, 16'h0C40, 16'h0C80, 16'h0CC0, 16'h0D00,
        16'h0D40, 16'h0D80, 16'h0DC0, 16'h0E00, 16'h0E40};
    logic [15:0] hi[19] = '{16'h0037, 16'h0047, 16'h009F, 16'h00B5, 16'h026F, 16'h05BD,
        16'h09FF, 16'h0A3F, 16'h0A7F, 16'h0C3F, 16'h0C7F, 16'h0CBF, 16'h0CFF, 16'h0D3F,
        16'h0D7F, 16'h0DBF, 16'h0DFF, 16'h0E3F, 16'h0E7F};
    // Clock of 100 ns period
    always #50 CLK_I = ~CLK_I;
    short_opcode_control_compare_decoder u_short_opcode_control_compare_decoder (
        .CLK_I(CLK_I), .RST_I(RST_I), .OPCODE_I(OPCODE_I), .OPCODE_VALID_I(OPCODE_VALID_I),
        .DEC_VALID_O(DEC_VALID_O), .OP_CLASS_O(OP_CLASS_O), .ILLEGAL_O(ILLEGAL_O),
        .INTERRUPT_DISABLE_OP_O(INTERRUPT_DISABLE_OP_O),
        .INTERRUPT_ENABLE_OP_O(INTERRUPT_ENABLE_OP_O), .RAISE_OP_O(RAISE_OP_O),
        .ATOMIC_BYTE_LOCK_OP_O(ATOMIC_BYTE_LOCK_OP_O),
        .DCACHE_LINE_INVALIDATE_OP_O(DCACHE_LINE_INVALIDATE_OP_O),
        .POP_MULTIPLE_OP_O(POP_MULTIPLE_OP_O), .COMPARE_OP_O(COMPARE_OP_O),
        .CONDITION_FLAG_WE_O(CONDITION_FLAG_WE_O),
        .UNSIGNED_COMPARE_OPTION_O(UNSIGNED_COMPARE_OPTION_O),
        .COMPARE_KIND_O(COMPARE_KIND_O), .COMPARE_USES_IMM_O(COMPARE_USES_IMM_O),
        .OPERAND_IS_POINTER_O(OPERAND_IS_POINTER_O), .REG_A_O(REG_A_O), .REG_B_O(REG_B_O),
        .IMMEDIATE_O(IMMEDIATE_O), .POST_INCREMENT_O(POST_INCREMENT_O),
        .DATA_REG_LIMIT_O(DATA_REG_LIMIT_O), .POINTER_REG_LIMIT_O(POINTER_REG_LIMIT_O),
        .STACK_POINTER_REG_UPDATE_O(STACK_POINTER_REG_UPDATE_O));
    fetch_model u_fetch_model (.clk_i(CLK_I), .req_i(req), .word_i(wd),
        .opcode_o(OPCODE_I), .valid_o(OPCODE_VALID_I));
    // Verdict and end of run
    task end_of_test;
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One comparison
    task chk(input logic [39:0] g, input logic [39:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Judge the decode of stream word k
    task look(input int k);
        logic [4:0] c;
        c = cl[k];
        chk(DEC_VALID_O, 1);
        chk(OP_CLASS_O, c);
        chk(ILLEGAL_O, c == 0);
        chk({INTERRUPT_DISABLE_OP_O, INTERRUPT_ENABLE_OP_O, RAISE_OP_O, ATOMIC_BYTE_LOCK_OP_O,
            DCACHE_LINE_INVALIDATE_OP_O, POP_MULTIPLE_OP_O}, (c >= 1 && c <= 6) ? 6'h20 >> (c - 1) : 0);
        chk({COMPARE_OP_O, CONDITION_FLAG_WE_O}, c >= 7 ? 2'h3 : 2'h0);
        chk(UNSIGNED_COMPARE_OPTION_O, c inside {7, 8, 9, [16:19]});
        chk(OPERAND_IS_POINTER_O, c inside {4, 5, 7, 9, 11, 13, 15, 17, 19});
    endtask
    // Back-to-back words, then one idle cycle
    task stream;
        for (int i = 0; i < wl.size(); i++) begin
            @(posedge CLK_I);
            req <= 1'b1;
            wd <= wl[i];
            @(negedge CLK_I);
            if (i > 0) look(i - 1);
        end
        @(posedge CLK_I);
        req <= 1'b0;
        @(negedge CLK_I);
        look(wl.size() - 1);
        @(negedge CLK_I);
        chk({DEC_VALID_O, OP_CLASS_O, ILLEGAL_O}, 0);
        wl.delete();
        cl.delete();
    endtask
    // Single word, outputs settled afterwards
    task one(input logic [15:0] w);
        @(posedge CLK_I);
        req <= 1'b1;
        wd <= w;
        @(posedge CLK_I);
        req <= 1'b0;
        @(negedge CLK_I);
    endtask
    // Outputs quiet after reset
    task t_reset;
        @(negedge CLK_I);
        chk({DEC_VALID_O, OP_CLASS_O, IMMEDIATE_O}, 0);
    endtask
    // Both bounds of every range
    task t_ranges;
        for (int j = 0; j < 19; j++) begin
            wl.push_back(lo[j]);
            cl.push_back(j + 1);
            wl.push_back(hi[j]);
            cl.push_back(j + 1);
        end
        stream();
    endtask
    // Near misses around the ranges, a legal word in between
    task t_illegal;
        wl = '{16'h0000, 16'h002F, 16'h0038, 16'h0048, 16'h0037, 16'h00A0, 16'h00B6, 16'h0267,
            16'h0270, 16'h057F, 16'h05BE, 16'h0980, 16'h0A80, 16'h0BFF, 16'h0E80, 16'hFFFF};
        cl = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
        stream();
    endtask
    // Operand fields and immediates
    task t_fields;
        one(16'h0C7C);
        chk({COMPARE_KIND_O, REG_A_O, IMMEDIATE_O}, {2'h0, 3'h4, 32'hFFFFFFFF});
        one(16'h0CA9);
        chk({COMPARE_KIND_O, IMMEDIATE_O}, {2'h1, 32'hFFFFFFFD});
        one(16'h0DFF);
        chk({COMPARE_KIND_O, COMPARE_USES_IMM_O, IMMEDIATE_O}, {2'h1, 1'h1, 32'h7});
        one(16'h0E7A);
        chk({COMPARE_KIND_O, IMMEDIATE_O}, {2'h2, 32'h7});
        one(16'h009B);
        chk(IMMEDIATE_O, 32'hB);
        one(16'h05AB);
        chk({DATA_REG_LIMIT_O, POINTER_REG_LIMIT_O, STACK_POINTER_REG_UPDATE_O,
            POST_INCREMENT_O}, 8'hAF);
        one(16'h0A1D);
        chk({REG_B_O, REG_A_O, COMPARE_KIND_O}, {6'h1D, 2'h2});
        one(16'h026A);
        chk({POST_INCREMENT_O, REG_A_O}, 4'hA);
    endtask
    // Reset, then the scenarios
    initial begin
        repeat (10) @(negedge CLK_I);
        RST_I = 1'b0;
        t_reset();
        t_ranges();
        t_illegal();
        t_fields();
        end_of_test();
    end
    // Watchdog well past the expected run
    initial begin
        #50000;
        failures++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
